// ### shared/psc_defines.vh
// Constants for the processing-state controller
// Assumes inclusion by bare name from design files
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// Register byte offsets
`define PSC_ADR_CTRL 4'h0
`define PSC_ADR_EXR 4'h4
`define PSC_ADR_STAT 4'h8
`define PSC_ADR_EVENT 4'hC
// Control register fields
`define PSC_CTRL_SOFTWARE_STANDBY_SELECT 0
`define PSC_CTRL_MEDIUM 1
`define PSC_CTRL_ICM_LO 4
`define PSC_CTRL_ICM_HI 5
`define PSC_CTRL_MSTOP_LO 8
`define PSC_CTRL_MSTOP_HI 15
// Writable control bits
`define PSC_CTRL_WMASK 32'h0000FF33
// Extended control register fields
`define PSC_EXR_MASK_LO 0
`define PSC_EXR_MASK_HI 2
`define PSC_EXR_TRACE 7
// Interrupt control modes
`define PSC_ICM_0 2'h0
`define PSC_ICM_2 2'h2
// Reset values
`define PSC_CTRL_RST 32'h00000000
`define PSC_EXR_RST 8'h07
`define PSC_MASK_ALL 3'h7
// Exception kinds
`define PSC_EXC_NONE 3'h0
`define PSC_EXC_RESET 3'h1
`define PSC_EXC_TRACE 3'h2
`define PSC_EXC_IRQ 3'h3
`define PSC_EXC_TRAP 3'h4
// Access targets and state counts
`define PSC_TGT_MEM 2'h0
`define PSC_TGT_IO 2'h1
`define PSC_TGT_EXT2 2'h2
`define PSC_TGT_EXT3 2'h3
`define PSC_ST_MEM 2'h1
`define PSC_ST_IO 2'h2
`define PSC_ST_EXT2 2'h2
`define PSC_ST_EXT3 2'h3
// Last exception-sequence count; the sequence spans five states (counts 0 to 4)
`define PSC_EXC_LEN 3'h4
// Medium-speed divider
`define PSC_MED_DIV 3'h3
`endif

// ### design/psc_state_ctrl.v
// CPU processing-state controller: reset, exception, execution,
// bus release and power-down sequencing plus bus-cycle state counting.
// Assumes a CPU core that reports instruction ends and executes vectors,
// and a classic Wishbone master for the control registers.
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "psc_defines.vh"
module psc_state_ctrl (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_n_i,
	// Device pins
	input wire chip_clear_n_pin_i,
	input wire nmi_pin_i,
	input wire hw_standby_pin_n_i,
	input wire wdt_overflow_i,
	// Core events
	input wire instr_end_i,
	input wire [2:0] instr_kind_i,
	input wire irq_req_i,
	input wire [2:0] irq_level_i,
	input wire wake_i,
	// Transfer controller
	input wire tc_bus_req_i,
	output reg tc_bus_grant_o,
	// Bus cycle request
	input wire acc_start_i,
	input wire [1:0] acc_target_i,
	input wire acc_wide_i,
	input wire acc_wait_i,
	output reg acc_done_o,
	output reg acc_wide_o,
	// State and control outputs
	output reg [2:0] proc_state_o,
	output reg [2:0] exc_kind_o,
	output reg exc_start_o,
	output reg manual_reset_o,
	output reg cpu_run_o,
	output reg clk_halt_o,
	output reg modules_reset_o,
	output reg clk_medium_en_o,
	output reg [7:0] module_stop_o,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o
);
	// Processing states, one-hot
	localparam ST_RESET = 6'b000001;
	localparam ST_EXC = 6'b000010;
	localparam ST_EXEC = 6'b000100;
	localparam ST_BUSREL = 6'b001000;
	localparam ST_SLEEP = 6'b010000;
	localparam ST_HW_STANDBY_PIN_N = 6'b100000;
	// Instruction kinds reported at instruction end
	localparam K_PLAIN = 3'h0;
	localparam K_CCR = 3'h1;
	localparam K_RTE = 3'h2;
	localparam K_TRAP = 3'h3;
	localparam K_SLEEP = 3'h4;
	reg [5:0] state;
	reg [5:0] next_state;
	reg [31:0] ctrl;
	reg [7:0] extended_control_reg;
	reg [2:0] exc_cnt;
	reg [2:0] exc_cur;
	reg irq_block;
	reg trap_pend;
	reg res_d;
	reg [2:0] med_cnt;
	reg [1:0] acc_cnt;
	reg acc_busy;
	reg acc_ext3;
	reg hw_hw_standby_pin_n;
	wire [1:0] icm;
	wire trace_on;
	wire wb_req;
	assign icm = ctrl[`PSC_CTRL_ICM_HI:`PSC_CTRL_ICM_LO];
	assign trace_on = extended_control_reg[`PSC_EXR_TRACE] && (icm == `PSC_ICM_2);
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Byte-lane merge for register writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction
	// State count per access target
	function [1:0] states_for;
		input [1:0] tgt;
		begin
			case (tgt)
				`PSC_TGT_MEM: states_for = `PSC_ST_MEM;
				`PSC_TGT_IO: states_for = `PSC_ST_IO;
				`PSC_TGT_EXT2: states_for = `PSC_ST_EXT2;
				default: states_for = `PSC_ST_EXT3;
			endcase
		end
	endfunction
	// Exception selection at an instruction boundary
	reg [2:0] pick;
	always @* begin
		pick = `PSC_EXC_NONE;
		if (instr_end_i && instr_kind_i == K_TRAP)
			pick = `PSC_EXC_TRAP;
		else if (trap_pend)
			pick = `PSC_EXC_TRAP;
		else if (instr_end_i && trace_on && instr_kind_i != K_RTE)
			pick = `PSC_EXC_TRACE;
		else if (instr_end_i && irq_req_i && !irq_block && instr_kind_i != K_CCR &&
				(irq_level_i > extended_control_reg[`PSC_EXR_MASK_HI:`PSC_EXR_MASK_LO] ||
				icm != `PSC_ICM_2))
			pick = `PSC_EXC_IRQ;
	end
	// Next processing state
	always @* begin
		next_state = state;
		case (state)
			ST_RESET: begin
				if (res_d)
					next_state = ST_EXC;
			end
			ST_EXC: begin
				if (exc_cnt == `PSC_EXC_LEN)
					next_state = ST_EXEC;
			end
			ST_EXEC: begin
				if (tc_bus_req_i && !acc_busy)
					next_state = ST_BUSREL;
				else if (pick != `PSC_EXC_NONE)
					next_state = ST_EXC;
				else if (instr_end_i && instr_kind_i == K_SLEEP)
					next_state = ctrl[`PSC_CTRL_SOFTWARE_STANDBY_SELECT] ? ST_HW_STANDBY_PIN_N : ST_SLEEP;
			end
			ST_BUSREL: begin
				if (!tc_bus_req_i)
					next_state = ST_EXEC;
			end
			ST_SLEEP: begin
				if (wake_i)
					next_state = ST_EXEC;
			end
			ST_HW_STANDBY_PIN_N: begin
				// Hardware standby leaves only once the pin has settled high
				if (wake_i && !hw_hw_standby_pin_n)
					next_state = ST_EXEC;
			end
			default: next_state = ST_RESET;
		endcase
	end
	// Main sequencer
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_RESET;
			extended_control_reg <= `PSC_EXR_RST;
			exc_cnt <= 3'h0;
			exc_cur <= `PSC_EXC_NONE;
			irq_block <= 1'b1;
			trap_pend <= 1'b0;
			res_d <= 1'b0;
			hw_hw_standby_pin_n <= 1'b0;
			exc_start_o <= 1'b0;
			exc_kind_o <= `PSC_EXC_NONE;
			manual_reset_o <= 1'b0;
			proc_state_o <= 3'h0;
			cpu_run_o <= 1'b0;
			clk_halt_o <= 1'b0;
			modules_reset_o <= 1'b1;
			tc_bus_grant_o <= 1'b0;
		end else begin
			res_d <= chip_clear_n_pin_i;
			exc_start_o <= 1'b0;
			hw_hw_standby_pin_n <= !hw_standby_pin_n_i;
			modules_reset_o <= !hw_standby_pin_n_i;
			if (!chip_clear_n_pin_i || wdt_overflow_i || !hw_standby_pin_n_i) begin
				state <= (wdt_overflow_i && chip_clear_n_pin_i && hw_standby_pin_n_i)
					? ST_EXC : (hw_standby_pin_n_i ? ST_RESET : ST_HW_STANDBY_PIN_N);
				if (!chip_clear_n_pin_i)
					manual_reset_o <= !nmi_pin_i;
				extended_control_reg <= `PSC_EXR_RST;
				irq_block <= 1'b1;
				trap_pend <= 1'b0;
				exc_cnt <= 3'h0;
				exc_cur <= `PSC_EXC_RESET;
				exc_start_o <= wdt_overflow_i && chip_clear_n_pin_i && hw_standby_pin_n_i;
				exc_kind_o <= `PSC_EXC_RESET;
				cpu_run_o <= 1'b0;
				tc_bus_grant_o <= 1'b0;
				clk_halt_o <= !hw_standby_pin_n_i;
				res_d <= 1'b0;
			end else begin
				state <= next_state;
				if (state == ST_RESET && res_d) begin
					exc_cur <= `PSC_EXC_RESET;
					exc_cnt <= 3'h0;
					exc_start_o <= 1'b1;
					exc_kind_o <= `PSC_EXC_RESET;
				end
				// Trap arriving with bus release is held
				if (state == ST_EXEC && tc_bus_req_i && !acc_busy && instr_end_i &&
						instr_kind_i == K_TRAP)
					trap_pend <= 1'b1;
				if (state == ST_EXEC && next_state == ST_EXC) begin
					exc_cur <= pick;
					exc_cnt <= 3'h0;
					exc_start_o <= 1'b1;
					exc_kind_o <= pick;
					if (pick == `PSC_EXC_TRAP)
						trap_pend <= 1'b0;
				end
				// Interrupts unblock once software loads the extended register
				if (state == ST_EXEC && wb_req && wb_we_i && wb_adr_i == `PSC_ADR_EXR &&
						wb_sel_i[0])
					extended_control_reg <= wb_dat_i[7:0];
				if (state == ST_EXEC && wb_req && wb_we_i && wb_adr_i == `PSC_ADR_EXR)
					irq_block <= 1'b0;
				if (state == ST_EXC) begin
					exc_cnt <= exc_cnt + 3'h1;
					if (exc_cnt == `PSC_EXC_LEN) begin
						if (exc_cur == `PSC_EXC_IRQ && icm == `PSC_ICM_2)
							extended_control_reg[`PSC_EXR_MASK_HI:`PSC_EXR_MASK_LO] <= irq_level_i;
						if (exc_cur == `PSC_EXC_TRACE || exc_cur == `PSC_EXC_IRQ ||
								exc_cur == `PSC_EXC_TRAP)
							extended_control_reg[`PSC_EXR_TRACE] <= 1'b0;
					end
				end
				tc_bus_grant_o <= (next_state == ST_BUSREL);
				cpu_run_o <= (next_state == ST_EXEC) || (next_state == ST_EXC);
				clk_halt_o <= (next_state == ST_HW_STANDBY_PIN_N);
			end
			case (state)
				ST_RESET: proc_state_o <= 3'h0;
				ST_EXC: proc_state_o <= 3'h1;
				ST_EXEC: proc_state_o <= 3'h2;
				ST_BUSREL: proc_state_o <= 3'h3;
				ST_SLEEP: proc_state_o <= 3'h4;
				ST_HW_STANDBY_PIN_N: proc_state_o <= 3'h5;
				default: proc_state_o <= 3'h0;
			endcase
		end
	end
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			med_cnt <= 3'h0;
			clk_medium_en_o <= 1'b1;
			module_stop_o <= 8'h00;
		end else begin
			module_stop_o <= ctrl[`PSC_CTRL_MSTOP_HI:`PSC_CTRL_MSTOP_LO];
			if (!ctrl[`PSC_CTRL_MEDIUM]) begin
				med_cnt <= 3'h0;
				clk_medium_en_o <= 1'b1;
			end else begin
				med_cnt <= (med_cnt == `PSC_MED_DIV) ? 3'h0 : med_cnt + 3'h1;
				clk_medium_en_o <= (med_cnt == `PSC_MED_DIV);
			end
		end
	end
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_cnt <= 2'h0;
			acc_busy <= 1'b0;
			acc_ext3 <= 1'b0;
			acc_done_o <= 1'b0;
			acc_wide_o <= 1'b0;
		end else begin
			acc_done_o <= 1'b0;
			if (!acc_busy && acc_start_i && cpu_run_o) begin
				acc_wide_o <= acc_wide_i;
				// Target held so a changing request cannot move the wait rule
				acc_ext3 <= (acc_target_i == `PSC_TGT_EXT3);
				if (states_for(acc_target_i) == `PSC_ST_MEM) begin
					acc_done_o <= 1'b1;
				end else begin
					acc_busy <= 1'b1;
					acc_cnt <= states_for(acc_target_i) - 2'h1;
				end
			end else if (acc_busy) begin
				if (acc_cnt == 2'h1 && !(acc_wait_i && acc_ext3)) begin
					acc_busy <= 1'b0;
					acc_done_o <= 1'b1;
					acc_cnt <= 2'h0;
				end else if (acc_cnt != 2'h1) begin
					acc_cnt <= acc_cnt - 2'h1;
				end
			end
		end
	end
	// Wishbone slave, ack one cycle after request
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= `PSC_CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && wb_we_i && wb_adr_i == `PSC_ADR_CTRL)
				// Control bits without a function read back as 0
				ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & `PSC_CTRL_WMASK;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`PSC_ADR_CTRL: wb_dat_o <= ctrl;
					`PSC_ADR_EXR: wb_dat_o <= {24'h000000, extended_control_reg};
					`PSC_ADR_STAT: wb_dat_o <= {18'h00000, state, 5'h00, manual_reset_o,
						tc_bus_grant_o, irq_block};
					`PSC_ADR_EVENT: wb_dat_o <= {26'h0000000, exc_cur, exc_cnt};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // psc_state_ctrl

// ### test/psc_state_ctrl_monitor.sv
// Concurrent checks on the processing-state controller ports
// Assumes one clock domain with asynchronous active-low reset
`timescale 1ns/1ns
`include "psc_defines.vh"
module psc_state_ctrl_monitor (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_n_i,
	// Pins and core events
	input wire chip_clear_n_pin_i,
	input wire nmi_pin_i,
	input wire hw_standby_pin_n_i,
	input wire wdt_overflow_i,
	input wire instr_end_i,
	input wire [2:0] instr_kind_i,
	// Bus release and access
	input wire tc_bus_grant_o,
	input wire acc_start_i,
	input wire [1:0] acc_target_i,
	input wire acc_wide_i,
	input wire acc_wait_i,
	input wire acc_done_o,
	input wire acc_wide_o,
	// State outputs
	input wire [2:0] proc_state_o,
	input wire [2:0] exc_kind_o,
	input wire exc_start_o,
	input wire manual_reset_o,
	input wire cpu_run_o,
	input wire clk_halt_o,
	input wire modules_reset_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence two_states;
		!acc_done_o ##1 acc_done_o;
	endsequence
	sequence three_states;
		!acc_done_o ##1 two_states;
	endsequence
	clear_enters_reset_a: assert property ((!chip_clear_n_pin_i)[*2] |=> proc_state_o == 3'h0)
		else $error("chip clear did not give reset state");
	manual_select_a: assert property ((!chip_clear_n_pin_i && !nmi_pin_i)[*2] |=> manual_reset_o)
		else $error("manual reset not selected");
	reset_vector_a: assert property ($rose(chip_clear_n_pin_i) |-> ##[1:3] (exc_start_o && exc_kind_o == `PSC_EXC_RESET))
		else $error("reset handling did not start");
	wdt_reset_a: assert property (wdt_overflow_i |-> ##[1:2] (exc_start_o && exc_kind_o == `PSC_EXC_RESET))
		else $error("watchdog reset not started");
	trap_taken_a: assert property (instr_end_i && instr_kind_i == 3'h3 && cpu_run_o |-> ##[1:3] (exc_start_o && exc_kind_o == `PSC_EXC_TRAP))
		else $error("trap not accepted");
	ccr_no_irq_a: assert property (instr_end_i && instr_kind_i == 3'h1 |=> (!(exc_start_o && exc_kind_o == `PSC_EXC_IRQ))[*3])
		else $error("interrupt taken after ccr instruction");
	bus_release_a: assert property (tc_bus_grant_o[*2] |-> proc_state_o == 3'h3)
		else $error("granted bus without released state");
	standby_halt_a: assert property ((!hw_standby_pin_n_i)[*2] |-> modules_reset_o && clk_halt_o)
		else $error("hardware standby not entered");
	mem_one_state_a: assert property (acc_start_i && cpu_run_o && acc_target_i == `PSC_TGT_MEM |=> acc_done_o && acc_wide_o == $past(acc_wide_i))
		else $error("memory access not one state");
	io_two_state_a: assert property (acc_start_i && cpu_run_o && acc_target_i == `PSC_TGT_IO |=> two_states)
		else $error("module access not two states");
	ext_three_state_a: assert property (acc_start_i && cpu_run_o && acc_target_i == `PSC_TGT_EXT3 && !acc_wait_i |=> three_states)
		else $error("external access not three states");
endmodule // psc_state_ctrl_monitor
bind psc_state_ctrl psc_state_ctrl_monitor i_psc_state_ctrl_monitor (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.chip_clear_n_pin_i(chip_clear_n_pin_i),
	.nmi_pin_i(nmi_pin_i),
	.hw_standby_pin_n_i(hw_standby_pin_n_i),
	.wdt_overflow_i(wdt_overflow_i),
	.instr_end_i(instr_end_i),
	.instr_kind_i(instr_kind_i),
	.tc_bus_grant_o(tc_bus_grant_o),
	.acc_start_i(acc_start_i),
	.acc_target_i(acc_target_i),
	.acc_wide_i(acc_wide_i),
	.acc_wait_i(acc_wait_i),
	.acc_done_o(acc_done_o),
	.acc_wide_o(acc_wide_o),
	.proc_state_o(proc_state_o),
	.exc_kind_o(exc_kind_o),
	.exc_start_o(exc_start_o),
	.manual_reset_o(manual_reset_o),
	.cpu_run_o(cpu_run_o),
	.clk_halt_o(clk_halt_o),
	.modules_reset_o(modules_reset_o)
);

// ### test/psc_tc_model.sv
// Transfer controller model asking for the bus
// Assumes grant is a level from the controller under test
`timescale 1ns/1ns
module psc_tc_model (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_n_i,
	// Control from bench
	input wire go_i,
	input wire [3:0] hold_i,
	output logic done_o,
	// Bus request
	input wire grant_i,
	output logic req_o
);
	logic [3:0] cnt;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_o <= 1'b0;
			done_o <= 1'b0;
			cnt <= 4'h0;
		end else if (go_i && !req_o) begin
			req_o <= 1'b1;
			done_o <= 1'b0;
			cnt <= 4'h0;
		end else if (req_o && grant_i) begin
			cnt <= cnt + 4'h1;
			if (cnt == hold_i) req_o <= 1'b0;
		end else if (!req_o && !grant_i && cnt != 4'h0) begin
			done_o <= 1'b1;
		end
	end
endmodule // psc_tc_model

// ### test/tb.sv
// Self-checking bench for the processing-state controller
// Assumes the bound monitor and the transfer controller model
`timescale 1ns/1ns
`include "psc_defines.vh"
module tb;
	logic sys_clk_i = 0, rst_n_i = 0, chip_clear_n_pin_i = 0, nmi_pin_i = 0, wake_i = 0;
	logic hw_standby_pin_n_i = 1, wdt_overflow_i = 0, instr_end_i = 0, irq_req_i = 0;
	logic acc_start_i = 0, acc_wide_i = 0, acc_wait_i = 0, acc_done_o, acc_wide_o;
	logic [2:0] instr_kind_i = 0, irq_level_i = 0, proc_state_o, exc_kind_o;
	logic [1:0] acc_target_i = 0;
	logic tc_bus_req_i, tc_bus_grant_o, exc_start_o, manual_reset_o, cpu_run_o;
	logic clk_halt_o, modules_reset_o, clk_medium_en_o, tc_go = 0, tc_done;
	logic [7:0] module_stop_o;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [3:0] wb_adr_i = 0, wb_sel_i = 0, tc_hold = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd, r;
	integer fail_count = 0, total_checks = 0, cycles = 0, i, seed, hits;
	psc_state_ctrl i_psc_state_ctrl (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.chip_clear_n_pin_i(chip_clear_n_pin_i), .nmi_pin_i(nmi_pin_i),
		.hw_standby_pin_n_i(hw_standby_pin_n_i), .wdt_overflow_i(wdt_overflow_i),
		.instr_end_i(instr_end_i), .instr_kind_i(instr_kind_i),
		.irq_req_i(irq_req_i), .irq_level_i(irq_level_i), .wake_i(wake_i),
		.tc_bus_req_i(tc_bus_req_i), .tc_bus_grant_o(tc_bus_grant_o),
		.acc_start_i(acc_start_i), .acc_target_i(acc_target_i),
		.acc_wide_i(acc_wide_i), .acc_wait_i(acc_wait_i),
		.acc_done_o(acc_done_o), .acc_wide_o(acc_wide_o),
		.proc_state_o(proc_state_o), .exc_kind_o(exc_kind_o),
		.exc_start_o(exc_start_o), .manual_reset_o(manual_reset_o),
		.cpu_run_o(cpu_run_o), .clk_halt_o(clk_halt_o),
		.modules_reset_o(modules_reset_o), .clk_medium_en_o(clk_medium_en_o),
		.module_stop_o(module_stop_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	psc_tc_model i_psc_tc_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .go_i(tc_go),
		.hold_i(tc_hold), .done_o(tc_done), .grant_i(tc_bus_grant_o), .req_o(tc_bus_req_i));
	always #5 sys_clk_i = ~sys_clk_i;
	task print_verdict;
		if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Three-state cycles gain the one wait state the stimulus asks for
	function automatic logic [31:0] lat(input logic [1:0] tg, input logic wt);
		lat = tg == `PSC_TGT_MEM ? `PSC_ST_MEM :
			tg == `PSC_TGT_EXT3 ? `PSC_ST_EXT3 + wt : `PSC_ST_IO;
	endfunction
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		{wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h3F;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge sys_clk_i);
		while (wb_ack_o !== 1'b1) @(posedge sys_clk_i);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task exp_exc(input logic [2:0] ek, input logic want);
		integer n;
		logic seen;
		seen = 1'b0;
		for (n = 0; n < 12; n = n + 1) begin
			@(posedge sys_clk_i);
			if (exc_start_o === 1'b1 && exc_kind_o === ek) seen = 1'b1;
		end
		chk_val(seen, want);
	endtask
	task ins(input logic [2:0] k, input logic [2:0] ek, input logic want);
		@(posedge sys_clk_i);
		instr_end_i <= 1'b1;
		instr_kind_i <= k;
		@(posedge sys_clk_i);
		instr_end_i <= 1'b0;
		exp_exc(ek, want);
	endtask
	task acc(input logic [1:0] tg, input logic w, input logic wt);
		integer n;
		@(posedge sys_clk_i);
		{acc_start_i, acc_target_i, acc_wide_i, acc_wait_i} <= {1'b1, tg, w, wt};
		@(posedge sys_clk_i);
		acc_start_i <= 1'b0;
		n = 1;
		@(posedge sys_clk_i);
		while (acc_done_o !== 1'b1 && n < 8) begin
			@(posedge sys_clk_i);
			n = n + 1;
			if (n == 2 && acc_done_o !== 1'b1) acc_wait_i <= 1'b0;
		end
		chk_val(n, lat(tg, wt));
		chk_val(acc_wide_o, w);
		acc_wait_i <= 1'b0;
	endtask
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count = fail_count + 1;
			print_verdict;
		end
	end
	initial begin
		seed = $urandom(62);
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		chk_val(manual_reset_o, 1'b1);
		chip_clear_n_pin_i <= 1'b1;
		exp_exc(`PSC_EXC_RESET, 1'b1);
		chk_val(proc_state_o, 3'h2);
		wb(1'b0, `PSC_ADR_CTRL, 32'h0);
		chk_val(rd, `PSC_CTRL_RST);
		wb(1'b0, `PSC_ADR_EXR, 32'h0);
		chk_val(rd, `PSC_EXR_RST);
		irq_req_i <= 1'b1;
		irq_level_i <= 3'h7;
		ins(3'h0, `PSC_EXC_IRQ, 1'b0);
		wb(1'b1, `PSC_ADR_CTRL, 32'h0000A522);
		repeat (2) @(posedge sys_clk_i);
		chk_val(module_stop_o, 8'hA5);
		hits = 0;
		repeat (8) begin
			@(posedge sys_clk_i);
			hits = hits + clk_medium_en_o;
		end
		chk_val(hits, 8 / (`PSC_MED_DIV + 1));
		wb(1'b1, `PSC_ADR_EXR, 32'h0);
		ins(3'h1, `PSC_EXC_IRQ, 1'b0);
		ins(3'h0, `PSC_EXC_IRQ, 1'b1);
		irq_req_i <= 1'b0;
		wb(1'b1, `PSC_ADR_EXR, 32'h83);
		ins(3'h0, `PSC_EXC_TRACE, 1'b1);
		wb(1'b0, `PSC_ADR_EXR, 32'h0);
		chk_val(rd, 32'h3);
		wb(1'b1, `PSC_ADR_EXR, 32'h83);
		ins(3'h2, `PSC_EXC_TRACE, 1'b0);
		wb(1'b1, `PSC_ADR_CTRL, 32'h0);
		ins(3'h0, `PSC_EXC_TRACE, 1'b0);
		ins(3'h3, `PSC_EXC_TRAP, 1'b1);
		for (i = 0; i < 2; i = i + 1) begin
			wb(1'b1, `PSC_ADR_CTRL, i);
			ins(3'h4, `PSC_EXC_TRAP, 1'b0);
			chk_val(proc_state_o, 3'h4 + i);
			chk_val(clk_halt_o, i);
			wake_i <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			wake_i <= 1'b0;
			@(posedge sys_clk_i);
			chk_val(proc_state_o, 3'h2);
		end
		wb(1'b0, 4'h2, 32'h0);
		chk_val(rd, 32'h0);
		for (i = 0; i < 40; i = i + 1) begin
			r = $urandom;
			acc(r[1:0], r[2], r[3]);
		end
		for (i = 1; i < 8; i = i + 5) begin
			tc_hold <= i[3:0];
			tc_go <= 1'b1;
			@(posedge sys_clk_i);
			tc_go <= 1'b0;
			repeat (20) @(posedge sys_clk_i);
			chk_val(tc_done, 1'b1);
		end
		wdt_overflow_i <= 1'b1;
		@(posedge sys_clk_i);
		wdt_overflow_i <= 1'b0;
		exp_exc(`PSC_EXC_RESET, 1'b1);
		nmi_pin_i <= 1'b1;
		chip_clear_n_pin_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk_val(manual_reset_o, 1'b0);
		chip_clear_n_pin_i <= 1'b1;
		exp_exc(`PSC_EXC_RESET, 1'b1);
		hw_standby_pin_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk_val({modules_reset_o, clk_halt_o}, 2'h3);
		print_verdict;
	end
endmodule // tb
